// ---- tbsp_ctrl_model.sv ----
// controller-side model: pin clocks, commands and write beats for the burst port
// assumes the bench calls cyc once per pin clock cycle, k low on entry
`default_nettype none

module tbsp_ctrl_model (
    input wire logic clk_sys,
    output var tbsp_pkg::tbsp_pins_t pins,
    output var logic probe,
    output var int half_no
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [35:0] pw0, pw1; // beats of the write loaded last cycle
    logic [3:0] pe0, pe1; // their lane enables
    logic pend; // a write still owes its data beats
    logic dual; // output clocks run with k, k_n instead of being tied high

    // single clock strap: output clocks tied high from power-on
    initial begin
        pins = '0;
        pins.c = 1'b1;
        pins.c_n = 1'b1;
        pins.k_n = 1'b1;
        pins.load_n = 1'b1;
        pins.bypass_n = 1'b1;
        probe = 1'b0;
        half_no = -2;
        pend = 1'b0;
        dual = 1'b0;
    end

    // strap and latency pins; only changed while the port is held in reset
    task automatic set_mode(input logic bypass, input logic sep);
        dual = sep;
        pins.bypass_n = bypass;
        pins.c = !sep;
        pins.c_n = 1'b1;
    endtask

    // one pin cycle; every level held 4 clk_sys cycles either side of its edge
    task automatic cyc(input int n, input logic ld_n, input logic rd, input logic [18:0] a,
                       input logic [35:0] w0, input logic [3:0] e0,
                       input logic [35:0] w1, input logic [3:0] e1);
        pins.load_n = ld_n;
        pins.dir_read = rd;
        pins.addr = a;
        // idle bus is inverted, never left showing the old beat
        pins.dq = pend ? pw0 : ~pins.dq;
        pins.be_n = pend ? pe0 : ~pins.be_n;
        repeat (3) @(negedge clk_sys);
        half_no = 2 * n - 1;
        probe = 1'b1;
        @(negedge clk_sys);
        probe = 1'b0;
        pins.k = 1'b1;
        pins.k_n = 1'b0;
        // zero skew output clocks, so read timing matches single clock mode
        pins.c = 1'b1;
        pins.c_n = !dual;
        repeat (4) @(negedge clk_sys);
        pins.dq = pend ? pw1 : ~pins.dq;
        pins.be_n = pend ? pe1 : ~pins.be_n;
        repeat (3) @(negedge clk_sys);
        half_no = 2 * n;
        probe = 1'b1;
        @(negedge clk_sys);
        probe = 1'b0;
        pins.k = 1'b0;
        pins.k_n = 1'b1;
        pins.c = !dual;
        pins.c_n = 1'b1;
        pend = !ld_n && !rd;
        {pw0, pe0, pw1, pe1} = {w0, e0, w1, e1};
        repeat (4) @(negedge clk_sys);
    endtask
endmodule

`default_nettype wire

// ---- tbsp_pkg.sv ----
// package for the two-word burst sram port: widths, lane layout, pin bundle
// assumes every user compiles this file first and names items as tbsp_pkg::name
`default_nettype none

package tbsp_pkg;
    // word and address geometry
    localparam int WORD_W = 36; // one data word
    localparam int ADDR_W = 19; // word address incl. burst bit
    localparam int LANE_W = 9; // one byte lane incl. its extra bit
    localparam int LANES = 4; // byte enables per word
    localparam int BURST_LEN = 2; // words per access
    // lane positions: lane n starts at n * LANE_W
    localparam int LANE0_LSB = 0;
    localparam int LANE1_LSB = 9;
    localparam int LANE2_LSB = 18;
    localparam int LANE3_LSB = 27;
    // pll-off operation is only legal up to this clock rate
    localparam int BYPASS_FMAX_MHZ = 167;
    // strap is caught once the pin synchroniser is full
    localparam logic [1:0] STRAP_WAIT = 2'h2;
    // reset values
    localparam logic [WORD_W-1:0] WORD_RST = 36'h0_0000_0000;
    localparam logic [ADDR_W-1:0] ADDR_RST = 19'h0_0000;

    // every pin that comes from the controller, carried as one bundle
    typedef struct packed {
        logic k;
        logic k_n;
        logic c;
        logic c_n;
        logic load_n;
        logic dir_read;
        logic bypass_n;
        logic [LANES-1:0] be_n;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] dq;
    } tbsp_pins_t;

    // one queued access: valid flag and its word address
    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
    } tbsp_slot_t;
endpackage

`default_nettype wire

// ---- tbsp_port.sv ----
// device-side logic of a two-word burst ddr sram port, memory array included
// assumes all pins are asynchronous to clk_sys and much slower than it, so that
// every edge of the memory clocks is seen after two synchroniser flops
`default_nettype none

module tbsp_port #(
    parameter int MEM_AW = tbsp_pkg::ADDR_W // array address width, shrink for sim
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic k_in,
    input wire logic k_n_in,
    input wire logic c_in,
    input wire logic c_n_in,
    input wire logic load_strobe_n,
    input wire logic dir_read,
    input wire logic [tbsp_pkg::ADDR_W-2:0] addr_in,
    input wire logic burst_lsb_in,
    input wire logic [tbsp_pkg::LANES-1:0] byte_enable_n,
    input wire logic pll_bypass_n,
    input wire logic [tbsp_pkg::WORD_W-1:0] dq_in,
    output logic [tbsp_pkg::WORD_W-1:0] dq_out,
    output logic dq_oe,
    output logic returned_strobe_pos,
    output logic returned_strobe_neg
);
    localparam int DEPTH = 2 ** MEM_AW;

    // second word of a burst: the one-bit counter wraps inside the pair
    function automatic logic [tbsp_pkg::ADDR_W-1:0] burst_next(
        input logic [tbsp_pkg::ADDR_W-1:0] a
    );
        return {a[tbsp_pkg::ADDR_W-1:1], ~a[0]};
    endfunction

    // merge a new word into an old one, lane by lane
    function automatic logic [tbsp_pkg::WORD_W-1:0] lane_merge(
        input logic [tbsp_pkg::WORD_W-1:0] old_w,
        input logic [tbsp_pkg::WORD_W-1:0] new_w,
        input logic [tbsp_pkg::LANES-1:0] be_n
    );
        logic [tbsp_pkg::WORD_W-1:0] r;
        r = old_w;
        for (int i = 0; i < tbsp_pkg::LANES; i++) begin
            if (!be_n[i]) begin
                r[i*tbsp_pkg::LANE_W +: tbsp_pkg::LANE_W] =
                    new_w[i*tbsp_pkg::LANE_W +: tbsp_pkg::LANE_W];
            end
        end
        return r;
    endfunction

    tbsp_pkg::tbsp_pins_t pins_raw; // bundle of raw pins
    tbsp_pkg::tbsp_pins_t sync1; // first synchroniser stage, read by sync2 only
    tbsp_pkg::tbsp_pins_t sync2; // pins safe to use in clk_sys
    logic [3:0] clk_last; // k, k_n, c, c_n one cycle behind sync2
    logic [1:0] strap_cnt; // waits for the synchroniser to fill
    logic strap_done; // accesses allowed from here on
    logic single_mode; // output data timed by k, k_n
    logic k_rise, kn_rise, out_pos, out_neg; // edge events
    logic pll_on; // 1.5 cycle read latency
    logic [tbsp_pkg::ADDR_W-1:0] load_addr; // address presented with the load
    tbsp_pkg::tbsp_slot_t rd_pend; // read loaded, waits for next k rise
    tbsp_pkg::tbsp_slot_t rd_arm; // read being returned
    logic rd_phase; // 0: first word still due, 1: second word due
    tbsp_pkg::tbsp_slot_t wr_pend; // write loaded, first word on next k rise
    tbsp_pkg::tbsp_slot_t wr_act; // first word stored, second on next k_n rise
    logic drive0, drive1; // read word launches
    logic wr0, wr1; // write word strobes
    logic [tbsp_pkg::ADDR_W-1:0] wr1_addr; // address of the second write word
    logic [tbsp_pkg::ADDR_W-1:0] rd0_addr; // address of the first read word
    logic [tbsp_pkg::ADDR_W-1:0] rd1_addr; // address of the second read word
    logic [tbsp_pkg::WORD_W-1:0] mem [DEPTH]; // the array, flip-flops

    assign pins_raw = '{k: k_in, k_n: k_n_in, c: c_in, c_n: c_n_in,
        load_n: load_strobe_n, dir_read: dir_read, bypass_n: pll_bypass_n,
        be_n: byte_enable_n, addr: {addr_in, burst_lsb_in}, dq: dq_in};

    // two-flop synchroniser for every pin, plus a delay stage for edges
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sync1 <= '0;
            sync2 <= '0;
            clk_last <= 4'h0;
        end else begin
            sync1 <= pins_raw;
            sync2 <= sync1;
            clk_last <= {sync2.k, sync2.k_n, sync2.c, sync2.c_n};
        end
    end

    // strap capture after reset release; both c pins high picks single clock
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            strap_cnt <= 2'h0;
            strap_done <= 1'b0;
            single_mode <= 1'b0;
        end else if (!strap_done) begin
            if (strap_cnt == tbsp_pkg::STRAP_WAIT) begin
                strap_done <= 1'b1;
                single_mode <= sync2.c & sync2.c_n;
            end else begin
                strap_cnt <= strap_cnt + 2'h1;
            end
        end
    end

    // edge events; the strap is fixed, so the output clock choice never moves
    assign k_rise = strap_done & sync2.k & ~clk_last[3];
    assign kn_rise = strap_done & sync2.k_n & ~clk_last[2];
    assign out_pos = single_mode ? k_rise : (strap_done & sync2.c & ~clk_last[1]);
    assign out_neg = single_mode ? kn_rise : (strap_done & sync2.c_n & ~clk_last[0]);
    assign pll_on = sync2.bypass_n;
    assign load_addr = sync2.addr;

    // read launches: pll off drives word 0 on the promoting k edge itself
    assign drive0 = pll_on ? (rd_arm.valid & ~rd_phase & out_neg)
                           : (k_rise & rd_pend.valid);
    assign drive1 = rd_arm.valid & rd_phase & (pll_on ? out_pos : out_neg);

    // write strobes: word 0 on the k rise after the load, word 1 on next k_n
    assign wr0 = k_rise & wr_pend.valid;
    assign wr1 = kn_rise & wr_act.valid;

    // word addresses named first so that each array index is a plain part-select
    assign wr1_addr = burst_next(wr_act.addr);
    assign rd0_addr = pll_on ? rd_arm.addr : rd_pend.addr;
    assign rd1_addr = burst_next(rd_arm.addr);

    // load decode; address only looked at when load is low
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_pend <= '0;
            wr_pend <= '0;
        end else if (k_rise) begin
            rd_pend.valid <= ~sync2.load_n & sync2.dir_read;
            wr_pend.valid <= ~sync2.load_n & ~sync2.dir_read;
            if (!sync2.load_n) begin
                rd_pend.addr <= load_addr;
                wr_pend.addr <= load_addr;
            end
        end
    end

    // read return slot; a new promotion may overlap the old second word
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rd_arm <= '0;
            rd_phase <= 1'b0;
        end else if (k_rise) begin
            rd_arm <= rd_pend;
            rd_phase <= ~pll_on; // word 0 already out when pll is off
        end else if (drive0) begin
            rd_phase <= 1'b1;
        end else if (drive1) begin
            rd_arm.valid <= 1'b0;
        end
    end

    // write slot for the second word
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_act <= '0;
        end else if (k_rise) begin
            wr_act <= wr_pend;
        end else if (wr1) begin
            wr_act.valid <= 1'b0;
        end
    end

    // array writes, byte lanes masked by the enables sampled with each word
    always_ff @(posedge clk_sys) begin
        if (wr0) begin
            mem[wr_pend.addr[MEM_AW-1:0]] <=
                lane_merge(mem[wr_pend.addr[MEM_AW-1:0]], sync2.dq, sync2.be_n);
        end
        if (wr1) begin
            mem[wr1_addr[MEM_AW-1:0]] <=
                lane_merge(mem[wr1_addr[MEM_AW-1:0]], sync2.dq, sync2.be_n);
        end
    end

    // read data and driver enable; release follows the next output pos edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dq_out <= tbsp_pkg::WORD_RST;
            dq_oe <= 1'b0;
        end else if (drive0) begin
            dq_out <= mem[rd0_addr[MEM_AW-1:0]];
            dq_oe <= 1'b1;
        end else if (drive1) begin
            dq_out <= mem[rd1_addr[MEM_AW-1:0]];
            dq_oe <= 1'b1;
        end else if (out_pos && !rd_arm.valid) begin
            dq_oe <= 1'b0;
        end
    end

    // echo clocks, free running, copied from whichever clock times the data
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            returned_strobe_pos <= 1'b0;
            returned_strobe_neg <= 1'b1;
        end else begin
            returned_strobe_pos <= single_mode ? sync2.k : sync2.c;
            returned_strobe_neg <= ~(single_mode ? sync2.k : sync2.c);
        end
    end

    // checks next to the logic
    sequence read_loaded_s;
        k_rise && !sync2.load_n && sync2.dir_read;
    endsequence

    sequence write_loaded_s;
        k_rise && !sync2.load_n && !sync2.dir_read;
    endsequence

    load_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        read_loaded_s |=> rd_pend.valid && !wr_pend.valid)
        else $error("read load not queued");

    load_write_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        write_loaded_s |=> wr_pend.valid && !rd_pend.valid)
        else $error("write load not queued");

    edge_only_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $changed(rd_pend.valid) || $changed(wr_pend.valid) |-> $past(k_rise))
        else $error("access started off a k rise");

    second_word_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr1 |=> !wr_act.valid)
        else $error("second write word not retired");

    bypass_latency_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        k_rise && rd_pend.valid && !pll_on |=> dq_oe ##0 rd_phase)
        else $error("pll off read not driven on promoting edge");

    pll_latency_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        k_rise && rd_pend.valid && pll_on |=> !rd_phase && rd_arm.valid)
        else $error("pll on read drove word early");

    release_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        out_pos && !rd_arm.valid && !drive0 |=> !dq_oe)
        else $error("drivers kept on with no read");

    oe_cause_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(dq_oe) |-> $past(drive0 || drive1))
        else $error("drivers enabled without a read word");

    echo_pair_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        returned_strobe_neg == !returned_strobe_pos)
        else $error("echo clocks not complementary");

    lane_keep_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr0 && sync2.be_n[0] |=> mem[$past(wr_pend.addr[MEM_AW-1:0])][8:0]
            == $past(mem[wr_pend.addr[MEM_AW-1:0]][8:0]))
        else $error("masked lane was written");

    // an unloaded k rise must leave both slots empty
    idle_ignored_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        k_rise && sync2.load_n |=> !rd_pend.valid && !wr_pend.valid)
        else $error("access queued without a load");

    load_addr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        k_rise && !sync2.load_n |=> rd_pend.addr == $past(sync2.addr)
            && wr_pend.addr == $past(sync2.addr))
        else $error("loaded address not held");

    echo_follow_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        out_pos |=> returned_strobe_pos && !returned_strobe_neg)
        else $error("echo clock missed an output clock rise");

    // word 0 comes from the promoted address itself, word 1 from its pair partner
    read_word_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        drive0 && pll_on |=> dq_oe && dq_out == $past(mem[rd_arm.addr[MEM_AW-1:0]]))
        else $error("first read word not from loaded address");

    burst_wrap_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        drive1 |=> dq_out
            == $past(mem[{rd_arm.addr[MEM_AW-1:1], !rd_arm.addr[0]}]))
        else $error("second read word not from paired address");
endmodule

`default_nettype wire

// ---- two_word_burst_sram_port_tb_top.sv ----
// self-checking bench for the burst port: single clock pll on, pll off, then c clocks
// assumes tbsp_pkg and tbsp_ctrl_model compiled first
`default_nettype none

module two_word_burst_sram_port_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int AW = 4; // shrunken array, upper address bits ignored
    logic clk_sys, rst_n, probe, dq_oe, spos, sneg, live, mode;
    tbsp_pkg::tbsp_pins_t pins;
    int half_no, errors, checked, cn;
    logic [35:0] dq_out;
    logic [35:0] ref_mem [16]; // expected array contents
    logic [35:0] exp_d [int]; // expected read beat per half cycle

    tbsp_ctrl_model u_model (.clk_sys(clk_sys), .pins(pins), .probe(probe), .half_no(half_no));

    tbsp_port #(.MEM_AW(AW)) DUT (
        .clk_sys(clk_sys), .rst_n(rst_n), .k_in(pins.k), .k_n_in(pins.k_n),
        .c_in(pins.c), .c_n_in(pins.c_n), .load_strobe_n(pins.load_n),
        .dir_read(pins.dir_read), .addr_in(pins.addr[18:1]), .burst_lsb_in(pins.addr[0]),
        .byte_enable_n(pins.be_n), .pll_bypass_n(pins.bypass_n), .dq_in(pins.dq),
        .dq_out(dq_out), .dq_oe(dq_oe), .returned_strobe_pos(spos), .returned_strobe_neg(sneg));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // lanes with enable low take the new byte, the others keep the old one
    function automatic logic [35:0] merge(input logic [35:0] o, input logic [35:0] w,
                                          input logic [3:0] e);
        for (int i = 0; i < 4; i++)
            if (!e[i]) o[9*i+:9] = w[9*i+:9];
        return o;
    endfunction

    // kind 0 write, 1 read, 2 idle; books expected beats before issuing
    task automatic op(input int kind, input logic [18:0] a, input logic [3:0] e0,
                      input logic [3:0] e1);
        logic [35:0] w0, w1;
        int i0, i1, lat;
        w0 = 36'({$urandom, $urandom});
        w1 = 36'({$urandom, $urandom});
        i0 = int'(a[AW-1:0]);
        i1 = i0 ^ 1;
        lat = mode ? 3 : 2;
        if (kind == 1) begin
            exp_d[2*cn+lat] = ref_mem[i0];
            exp_d[2*cn+lat+1] = ref_mem[i1];
        end else if (kind == 0) begin
            ref_mem[i0] = merge(ref_mem[i0], w0, e0);
            ref_mem[i1] = merge(ref_mem[i1], w1, e1);
        end
        u_model.cyc(cn, kind == 2, kind == 2 ? 1'($urandom) : kind == 1, a, w0, e0, w1, e1);
        cn++;
    endtask

    // settled half: read beat, driver enable, echo clocks
    always @(posedge probe) begin
        if (live) begin
            if (exp_d.exists(half_no)) begin
                check(dq_out, exp_d[half_no]);
                check(dq_oe, 1'b1);
            end else if (!exp_d.exists(half_no - 1) && !exp_d.exists(half_no - 2))
                check(dq_oe, 1'b0);
            check(spos, !half_no[0]);
            check(sneg, half_no[0]);
        end
    end

    initial begin
        logic [18:0] a, prev;
        int kind, last;
        errors = 0;
        checked = 0;
        live = 1'b0;
        mode = 1'b1;
        rst_n = 1'b0;
        cn = 0;
        last = 2;
        prev = '0;
        void'($urandom(50));
        // pass 2 and 1 strap single clock, pass 0 runs separate output clocks
        for (int m = 2; m >= 0; m--) begin
            mode = (m != 1);
            rst_n = 1'b0;
            u_model.set_mode(mode, m == 0);
            exp_d.delete();
            cn = 0;
            live = 1'b0;
            repeat (20) @(negedge clk_sys);
            check(dq_oe, 1'b0);
            check(sneg, 1'b1);
            rst_n = 1'b1;
            repeat (4) @(negedge clk_sys);
            live = 1'b1;
            // fill every word, odd start on odd pairs so the burst wraps
            for (int k = 0; k < 8; k++)
                op(0, 19'(2 * k + (k & 1)), 4'h0, 4'h0);
            $display("test fill done pass %0d", m);
            // random mix; no write right after a read of the same pair
            for (int k = 0; k < 40; k++) begin
                kind = $urandom_range(2);
                a = 19'($urandom);
                if (kind == 0 && last == 1 && a[AW-1:1] == prev[AW-1:1])
                    kind = 1;
                op(kind, a, 4'($urandom), 4'($urandom));
                last = kind;
                prev = a;
            end
            $display("test random done pass %0d", m);
            // masked lanes, high address bits ignored, wrap read
            op(0, 19'h7_FFF5, 4'hF, 4'h5);
            op(1, 19'h7_FFF5, 4'h0, 4'h0);
            op(1, 19'h0_0004, 4'h0, 4'h0);
            repeat (3)
                op(2, 19'($urandom), 4'h0, 4'h0);
            $display("test corner done pass %0d", m);
        end
        test_done();
    end

    // run is about 133 us over three passes; a hang stops here
    initial begin
        #500000;
        errors++;
        test_done();
    end
endmodule

`default_nettype wire
